// [rtl/fieldbus_bit_cell.v]
// One bit of control request and activation state for a single interface or protocol
module fieldbus_bit_cell #(
    parameter [0:0] CONTROL_RESET = 1'b0,
    parameter [0:0] ACTIVE_RESET = 1'b0
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire write_bit,
    input wire wdata_bit,
    input wire switchable,
    input wire available,
    output reg control_bit,
    output reg active_bit
);

    // ----------------------------------------
    // Request and activation
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_bit <= CONTROL_RESET;
            active_bit <= ACTIVE_RESET;
        end else if (ce) begin
            if (write_bit && switchable) begin
                control_bit <= wdata_bit;
            end
            // Locked bits keep their state whatever software requests
            if (switchable) begin
                active_bit <= control_bit & available;
            end
        end
    end

endmodule // fieldbus_bit_cell

// [rtl/fieldbus_select_map.vh]
// Offsets, field positions and reset values of the fieldbus selection registers
//
// Functional notes
// - Availability word: bits 0-15 physical interfaces, bits 16-31 protocol in use.
// - Low bits: 0 USB, 1 differential serial, 2 single-ended serial, 3 CAN, 4 Ethernet, 5 EtherType link, 6 SPI.
// - Protocol bits: 16 serial Modbus, 17 TCP Modbus, 18 industrial IP protocol.
// - Availability word is read-only and resets to Ethernet plus TCP Modbus only.
// - A read/write control word switches interfaces and protocols on or off.
// - Control word uses the same bit layout as the availability word.
// - Only bits marked switchable in the capability mask change through the control word.
// - Active set is shown in a separate read-only status word.
// - Capability mask bit one means software may deactivate that interface or protocol.
// - Status word bit one means that interface or protocol is currently active.
`ifndef FIELDBUS_SELECT_MAP_VH
`define FIELDBUS_SELECT_MAP_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define IDX_INTERFACE_AVAILABILITY 16'h2101
`define IDX_INTERFACE_ACTIVATION_CONTROL 16'h2102
`define IDX_CAPABILITY_MASK 16'h2103
`define IDX_ACTIVATION_STATUS 16'h2104
`define ADDR_WIDTH 18
`define ADDR_OF(idx) {idx, 2'b00}

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define BIT_USB 0
`define BIT_DIFFERENTIAL_SERIAL 1
`define BIT_SINGLE_ENDED_SERIAL 2
`define BIT_CAN 3
`define BIT_ETHERNET_PHY 4
`define BIT_INDUSTRIAL_ETHER_LINK 5
`define BIT_SPI 6
`define BIT_SERIAL_MODBUS_PROTOCOL 16
`define BIT_TCP_MODBUS_PROTOCOL 17
`define BIT_INDUSTRIAL_IP_PROTOCOL 18
`define PROTOCOL_LSB 16
`define DEFINED_BITS 32'h0007_007F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_INTERFACE_AVAILABILITY 32'h0002_0010
`define RST_INTERFACE_ACTIVATION_CONTROL 32'h0002_0010
`define RST_CAPABILITY_MASK 32'h0000_0000
`define RST_ACTIVATION_STATUS 32'h0002_0010

`endif

// [rtl/fieldbus_select_registers.v]
// APB register bank reporting and switching fieldbus interfaces and protocols
//
// Design decision made here: the APB register port.
`include "fieldbus_select_map.vh"

module fieldbus_select_registers (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] capability_pins,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [31:0] active_interfaces,
    output reg activation_changed
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    localparam [`ADDR_WIDTH-1:0] ADDR_AVAIL = `ADDR_OF(`IDX_INTERFACE_AVAILABILITY);
    localparam [`ADDR_WIDTH-1:0] ADDR_CTRL = `ADDR_OF(`IDX_INTERFACE_ACTIVATION_CONTROL);
    localparam [`ADDR_WIDTH-1:0] ADDR_CAP = `ADDR_OF(`IDX_CAPABILITY_MASK);
    localparam [`ADDR_WIDTH-1:0] ADDR_STAT = `ADDR_OF(`IDX_ACTIVATION_STATUS);
    localparam [31:0] DEFINED = `DEFINED_BITS;

    wire sel_avail;
    wire sel_ctrl;
    wire sel_cap;
    wire sel_stat;
    wire mapped;
    wire access;
    wire complete;
    wire write_ok;
    wire [31:0] lane_mask;

    assign sel_avail = (paddr == ADDR_AVAIL);
    assign sel_ctrl = (paddr == ADDR_CTRL);
    assign sel_cap = (paddr == ADDR_CAP);
    assign sel_stat = (paddr == ADDR_STAT);
    assign mapped = sel_avail | sel_ctrl | sel_cap | sel_stat;
    assign access = psel & penable;
    // One wait state: pready rises the cycle after the access phase opens
    assign complete = access & pready;
    // Only the control word accepts writes; the others are read-only
    assign write_ok = complete & pwrite & sel_ctrl;
    assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // ----------------------------------------
    // Availability word
    // ----------------------------------------
    // Each field is named on its own so that a later strap capture can
    // drive one interface without touching the others or the read path.
    localparam [31:0] AVAIL_FIXED = `RST_INTERFACE_AVAILABILITY;
    localparam [31:0] CTRL_RESET = `RST_INTERFACE_ACTIVATION_CONTROL;
    localparam [31:0] STAT_RESET = `RST_ACTIVATION_STATUS;

    // Physical interfaces
    wire usb_bit;
    wire differential_serial_bit;
    wire single_ended_serial_bit;
    wire can_bit;
    wire ethernet_phy_bit;
    wire industrial_ether_link_bit;
    wire spi_bit;
    // Protocols in use
    wire serial_modbus_protocol_bit;
    wire tcp_modbus_protocol_bit;
    wire industrial_ip_protocol_bit;

    assign usb_bit = AVAIL_FIXED[`BIT_USB];
    assign differential_serial_bit = AVAIL_FIXED[`BIT_DIFFERENTIAL_SERIAL];
    assign single_ended_serial_bit = AVAIL_FIXED[`BIT_SINGLE_ENDED_SERIAL];
    assign can_bit = AVAIL_FIXED[`BIT_CAN];
    assign ethernet_phy_bit = AVAIL_FIXED[`BIT_ETHERNET_PHY];
    assign industrial_ether_link_bit = AVAIL_FIXED[`BIT_INDUSTRIAL_ETHER_LINK];
    assign spi_bit = AVAIL_FIXED[`BIT_SPI];
    assign serial_modbus_protocol_bit = AVAIL_FIXED[`BIT_SERIAL_MODBUS_PROTOCOL];
    assign tcp_modbus_protocol_bit = AVAIL_FIXED[`BIT_TCP_MODBUS_PROTOCOL];
    assign industrial_ip_protocol_bit = AVAIL_FIXED[`BIT_INDUSTRIAL_IP_PROTOCOL];

    reg [31:0] next_availability;
    reg [31:0] availability;

    // Interfaces in the low half, protocols in the high half
    always @* begin
        next_availability = 32'h0000_0000;
        next_availability[`BIT_USB] = usb_bit;
        next_availability[`BIT_DIFFERENTIAL_SERIAL] = differential_serial_bit;
        next_availability[`BIT_SINGLE_ENDED_SERIAL] = single_ended_serial_bit;
        next_availability[`BIT_CAN] = can_bit;
        next_availability[`BIT_ETHERNET_PHY] = ethernet_phy_bit;
        next_availability[`BIT_INDUSTRIAL_ETHER_LINK] = industrial_ether_link_bit;
        next_availability[`BIT_SPI] = spi_bit;
        next_availability[`BIT_SERIAL_MODBUS_PROTOCOL] = serial_modbus_protocol_bit;
        next_availability[`BIT_TCP_MODBUS_PROTOCOL] = tcp_modbus_protocol_bit;
        next_availability[`BIT_INDUSTRIAL_IP_PROTOCOL] = industrial_ip_protocol_bit;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            availability <= `RST_INTERFACE_AVAILABILITY;
        end else if (ce) begin
            // Undefined positions can never read as available
            availability <= next_availability & DEFINED;
        end
    end

    // ----------------------------------------
    // Capability mask from pins
    // ----------------------------------------
    reg [31:0] capability_meta;
    reg [31:0] capability_sync;
    reg [31:0] capability_mask;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capability_meta <= `RST_CAPABILITY_MASK;
            capability_sync <= `RST_CAPABILITY_MASK;
            capability_mask <= `RST_CAPABILITY_MASK;
        end else if (ce) begin
            capability_meta <= capability_pins;
            capability_sync <= capability_meta;
            // Nothing absent or undefined can ever be switchable
            capability_mask <= capability_sync & availability & DEFINED;
        end
    end

    // ----------------------------------------
    // Per-bit control and activation cells
    // ----------------------------------------
    wire [31:0] control_word;
    wire [31:0] active_word;
    wire [31:0] write_bits;

    assign write_bits = {32{write_ok}} & lane_mask;

    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            if (DEFINED[i]) begin : g_cell
                fieldbus_bit_cell #(
                    .CONTROL_RESET(CTRL_RESET[i]),
                    .ACTIVE_RESET(STAT_RESET[i])
                ) u_cell (
                    .pclk(pclk),
                    .presetn(presetn),
                    .ce(ce),
                    .write_bit(write_bits[i]),
                    .wdata_bit(pwdata[i]),
                    .switchable(capability_mask[i]),
                    .available(availability[i]),
                    .control_bit(control_word[i]),
                    .active_bit(active_word[i])
                );
            end else begin : g_none
                // Reserved bits read as zero
                assign control_word[i] = 1'b0;
                assign active_word[i] = 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------
    // Status outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_interfaces <= `RST_ACTIVATION_STATUS;
            activation_changed <= 1'b0;
        end else if (ce) begin
            active_interfaces <= active_word;
            activation_changed <= (active_word != active_interfaces);
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    reg [31:0] next_prdata;

    always @* begin
        next_prdata = 32'h0000_0000;
        if (sel_avail) begin
            next_prdata = availability;
        end else if (sel_ctrl) begin
            next_prdata = control_word;
        end else if (sel_cap) begin
            next_prdata = capability_mask;
        end else if (sel_stat) begin
            // Status is separate from the request it follows
            next_prdata = active_word;
        end
    end

    // ----------------------------------------
    // APB handshake
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (access && !pready) begin
                pready <= 1'b1;
                // Writes to read-only words are refused, contents unchanged
                pslverr <= !mapped || (pwrite && !sel_ctrl);
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule // fieldbus_select_registers

// [verification/fieldbus_select_properties.sv]
// Port-level checker for the fieldbus selection register bank
`include "fieldbus_select_map.vh"
module fieldbus_select_checker (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] capability_pins,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] active_interfaces,
    input wire activation_changed
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire done = psel && penable && pready;
    wire rd_done = done && !pwrite;
    wire wr_done = done && pwrite;
    wire at_av = paddr == `ADDR_OF(`IDX_INTERFACE_AVAILABILITY);
    wire at_ro = paddr == `ADDR_OF(`IDX_CAPABILITY_MASK) || paddr == `ADDR_OF(`IDX_ACTIVATION_STATUS);
    wire mapped = at_av || at_ro || paddr == `ADDR_OF(`IDX_INTERFACE_ACTIVATION_CONTROL);
    // Mask needs pins quiet for a while: sync plus status plus output stage
    logic [3:0] quiet_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_cnt <= 4'h0;
        else if (capability_pins != 32'h0000_0000) quiet_cnt <= 4'h0;
        else if (quiet_cnt != 4'hf) quiet_cnt <= quiet_cnt + 4'h1;
    end
    avail_read_a: assert property (rd_done && at_av |-> prdata == 32'h0002_0010 && !pslverr)
        else $error("availability read wrong");
    avail_write_a: assert property (wr_done && at_av |-> pslverr)
        else $error("availability write not refused");
    reserved_bits_a: assert property (rd_done |-> (prdata & ~`DEFINED_BITS) == 32'h0000_0000)
        else $error("reserved bits set in read data");
    active_subset_a: assert property ((active_interfaces & ~32'h0002_0010) == 32'h0000_0000)
        else $error("active bit outside availability");
    one_wait_a: assert property (ce && psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait");
    status_write_a: assert property (wr_done && at_ro |-> pslverr)
        else $error("read-only write not refused");
    unmapped_a: assert property (done && !mapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    locked_hold_a: assert property (quiet_cnt == 4'hf |-> $stable(active_interfaces))
        else $error("active set changed without switchable bits");
endmodule // fieldbus_select_checker
bind fieldbus_select_registers fieldbus_select_checker fieldbus_select_checker_inst (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .capability_pins(capability_pins), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_interfaces(active_interfaces), .activation_changed(activation_changed));

// [verification/tb_fieldbus_select_registers.sv]
// Self-checking bench for the fieldbus selection register bank
`include "fieldbus_select_map.vh"
module tb_fieldbus_select_registers;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [17:0] AV = `ADDR_OF(`IDX_INTERFACE_AVAILABILITY);
    localparam [17:0] CT = `ADDR_OF(`IDX_INTERFACE_ACTIVATION_CONTROL);
    localparam [17:0] MK = `ADDR_OF(`IDX_CAPABILITY_MASK);
    localparam [17:0] ST = `ADDR_OF(`IDX_ACTIVATION_STATUS);
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, capability_pins = 0, prdata, active_interfaces;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, activation_changed;
    int fails = 0, total_checks = 0, changes = 0;
    always #20 pclk = ~pclk;
    always @(posedge pclk) if (activation_changed === 1'b1) changes++;
    fieldbus_select_registers fieldbus_select_registers_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .capability_pins(capability_pins), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .active_interfaces(active_interfaces), .activation_changed(activation_changed));
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask
    // Holds the request until pready is seen at a rising edge
    task xfer(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
              input logic [31:0] exp, input logic err);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (!w) chk("read data", exp, prdata);
        chk("error flag", {31'h0, err}, {31'h0, pslverr});
        psel <= 0; penable <= 0;
    endtask
    initial begin
        repeat (2000) @(posedge pclk);
        fails++;
        conclude;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        xfer(0, AV, 0, 0, 32'h0002_0010, 0);
        xfer(0, CT, 0, 0, 32'h0002_0010, 0);
        xfer(0, MK, 0, 0, 32'h0000_0000, 0);
        xfer(0, ST, 0, 0, 32'h0002_0010, 0);
        chk("active set", 32'h0002_0010, active_interfaces);
        xfer(1, AV, 0, 4'hf, 0, 1);
        xfer(0, AV, 0, 0, 32'h0002_0010, 0);
        xfer(0, 18'h0_0000, 0, 0, 0, 1);
        // Nothing switchable yet: the write must not stick
        xfer(1, CT, 0, 4'hf, 0, 0);
        xfer(0, CT, 0, 0, 32'h0002_0010, 0);
        repeat (3) @(posedge pclk);
        chk("active locked", 32'h0002_0010, active_interfaces);
        capability_pins <= 32'hffff_ffff;
        repeat (5) @(posedge pclk);
        xfer(0, MK, 0, 0, 32'h0002_0010, 0);
        xfer(1, MK, 0, 4'hf, 0, 1);
        xfer(1, ST, 0, 4'hf, 0, 1);
        // Byte lane 2 only: drops the protocol bit, keeps the interface bit
        xfer(1, CT, 0, 4'b0100, 0, 0);
        xfer(0, CT, 0, 0, 32'h0000_0010, 0);
        repeat (3) @(posedge pclk);
        xfer(0, ST, 0, 0, 32'h0000_0010, 0);
        chk("active after clear", 32'h0000_0010, active_interfaces);
        xfer(1, CT, 32'hffff_ffff, 4'hf, 0, 0);
        xfer(0, CT, 0, 0, 32'h0002_0010, 0);
        repeat (3) @(posedge pclk);
        chk("active after set", 32'h0002_0010, active_interfaces);
        // One pulse for the clear and one for the set, none at reset
        chk("change pulses", 32'd2, changes);
        conclude;
    end
endmodule // tb_fieldbus_select_registers
